// ===== logic/pdm_pkg.sv
// constants for the port d upper pin multiplexer
// assumes a 32-bit axi4-lite register bus and one 25 MHz clock
package pdm_pkg;
    localparam int unsigned PDM_DATA_W = 32;
    localparam int unsigned PDM_ADDR_W = 8;
    // register byte offsets
    localparam logic [7:0] PDM_OFF_PINS = 8'h00;
    localparam logic [7:0] PDM_OFF_LAT = 8'h04;
    localparam logic [7:0] PDM_OFF_DIR = 8'h08;
    localparam logic [7:0] PDM_OFF_PORT_A_LATCH_AND_PULLUPS = 8'h0C;
    localparam logic [7:0] PDM_OFF_MODE = 8'h10;
    // field positions in the shared pull-up/latch register
    localparam int unsigned PDM_BIT_PU_D = 7;
    localparam int unsigned PDM_BIT_PU_E = 6;
    // field positions in the mode register
    localparam int unsigned PDM_BIT_EXT_BUS_DISABLE = 0;
    localparam int unsigned PDM_BIT_HPM = 1;
    localparam int unsigned PDM_BIT_I2C = 2;
    localparam int unsigned PDM_BIT_SPI = 3;
    localparam int unsigned PDM_BIT_SMALL = 4;
    // reset values
    localparam logic [7:0] PDM_RST_DIR = 8'hFF;
    localparam logic [7:0] PDM_RST_LAT = 8'h00;
    localparam logic [7:0] PDM_RST_PORT_A_LATCH_AND_PULLUPS = 8'h00;
    localparam logic [4:0] PDM_RST_MODE = 5'h00;
    // bits present only on the full package
    localparam logic [7:0] PDM_FULL_MASK = 8'hF8;
    localparam logic [1:0] PDM_RESP_OKAY = 2'h0;
    localparam logic [1:0] PDM_RESP_SLVERR = 2'h2;
endpackage

// ===== logic/pdm_port_d_upper.sv
// port d register set and pin multiplexer for pins 5 to 7
// assumes synchronous pins, one clock, axi4-lite register access
// Contract
// [R01] direction 0 drives latch onto pin; 1 makes input, read returns pin
// [R02] shared register bit 7 enables port d pull-ups, bit 6 port e
// [R03] memory interface overrides every other function on these pins
// [R04] memory mode: pin n carries address/data bit n, direction ignored
// [R05] host port: pin drives latch, accepts host writes, ignores direction (the pin driver stays off in host mode; pin_out shows the latch only)
// [R06] pin 5 is spi data input when its direction bit is 1
// [R07] pin 6 spi clock: output when direction 0, input when 1
// [R08] i2c mode: pin 5 data, pin 6 clock, drive overrides port data
// [R09] pin 7 is spi slave select, sampled regardless of direction
// [R10] small package: bits 3 to 7 absent, read as zero
// [R11] don't-care functions override the direction bit
// [R12] host port enabled automatically when mode bit set
// [R13] port functions only while external bus disable bit set
// [R14] reset sets direction bits to input, pull-ups off
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/100ps
module pdm_port_d_upper
    import pdm_pkg::*;
(
    input wire logic aclk, // core clock
    input wire logic aresetn, // synchronous reset, low active
    input wire logic [pdm_pkg::PDM_ADDR_W-1:0] s_axi_awaddr, // write addr
    input wire logic s_axi_awvalid, // write addr valid
    output logic s_axi_awready, // write addr ready
    input wire logic [pdm_pkg::PDM_DATA_W-1:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // byte enables
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [pdm_pkg::PDM_ADDR_W-1:0] s_axi_araddr, // read addr
    input wire logic s_axi_arvalid, // read addr valid
    output logic s_axi_arready, // read addr ready
    output logic [pdm_pkg::PDM_DATA_W-1:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic [7:5] pin_in, // pad levels
    output logic [7:5] pin_out, // pad drive value
    output logic [7:5] pin_oe_n, // pad enable, low drives
    output logic [7:5] pin_pullup, // weak pull-up on
    input wire logic [7:5] mem_bus_out, // memory address/data out
    input wire logic mem_bus_drive, // memory bus is driving
    output logic [7:5] mem_bus_in, // memory data in
    input wire logic host_wr_strobe, // host port write strobe
    output logic [7:5] host_wr_data, // host write data captured
    input wire logic spi_clock_out, // spi master clock
    input wire logic i2c_data_out, // i2c data, 0 pulls low
    input wire logic i2c_clock_out, // i2c clock, 0 pulls low
    output logic spi_data_in, // spi data to module
    output logic spi_clock_in, // spi slave clock to module
    output logic spi_slave_select, // slave select to module
    output logic i2c_data_in, // i2c data to module
    output logic i2c_clock_in, // i2c clock to module
    output logic port_e_pullup_enable // neighbour port pull-up
);
    // ==========================================================
    // registers
    logic [7:0] lat_q;
    logic [7:0] dir_q;
    logic [7:0] port_a_latch_and_pullups_q;
    logic [4:0] mode_q;
    logic [7:0] impl_mask;
    logic ext_bus_disable;
    logic host_port_mode_bit;
    logic i2c_mode;
    logic spi_mode;
    logic mem_owns;
    logic port_d_pullup_enable;

    // ==========================================================
    // mode decode
    assign ext_bus_disable = mode_q[PDM_BIT_EXT_BUS_DISABLE];
    assign host_port_mode_bit = mode_q[PDM_BIT_HPM];
    assign i2c_mode = mode_q[PDM_BIT_I2C];
    assign spi_mode = mode_q[PDM_BIT_SPI];
    assign impl_mask = mode_q[PDM_BIT_SMALL] ? ~PDM_FULL_MASK : 8'hFF; // R10
    assign mem_owns = ~ext_bus_disable; // R13
    assign port_d_pullup_enable = port_a_latch_and_pullups_q[PDM_BIT_PU_D]; // R02

    // ==========================================================
    // axi4-lite write channel
    logic aw_held_q;
    logic w_held_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_go;

    // address and data are held in either order until the response
    assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held_q & ~s_axi_bvalid;
    assign wr_go = aw_held_q & w_held_q & ~s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held_q <= 1'b0;
            end
        end
    end

    logic wr_hit;
    always_comb begin
        unique case (awaddr_q)
            PDM_OFF_PINS, PDM_OFF_LAT, PDM_OFF_DIR,
            PDM_OFF_PORT_A_LATCH_AND_PULLUPS, PDM_OFF_MODE: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= PDM_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? PDM_RESP_OKAY : PDM_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ==========================================================
    // register updates; writing the pin register loads the latch
    logic wr_lane0;
    logic wr_lat;
    logic wr_dir;
    logic wr_port_a_latch_and_pullups;
    logic wr_mode;

    assign wr_lane0 = wr_go & wstrb_q[0];
    assign wr_lat = wr_lane0 &&
                    (awaddr_q == PDM_OFF_LAT || awaddr_q == PDM_OFF_PINS);
    assign wr_dir = wr_lane0 && awaddr_q == PDM_OFF_DIR;
    assign wr_port_a_latch_and_pullups = wr_lane0 && awaddr_q == PDM_OFF_PORT_A_LATCH_AND_PULLUPS;
    assign wr_mode = wr_lane0 && awaddr_q == PDM_OFF_MODE;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lat_q <= PDM_RST_LAT;
        end else if (wr_lat) begin
            lat_q <= wdata_q[7:0] & impl_mask; // R10
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dir_q <= PDM_RST_DIR; // R14
        end else if (wr_dir) begin
            dir_q <= wdata_q[7:0] & impl_mask; // R10
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_a_latch_and_pullups_q <= PDM_RST_PORT_A_LATCH_AND_PULLUPS; // R14
        end else if (wr_port_a_latch_and_pullups) begin
            port_a_latch_and_pullups_q <= wdata_q[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= PDM_RST_MODE;
        end else if (wr_mode) begin
            mode_q <= wdata_q[4:0];
        end
    end

    // ==========================================================
    // axi4-lite read channel
    logic [7:5] pins_q;
    logic [31:0] rd_word;
    logic rd_hit;

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            PDM_OFF_PINS: rd_word[7:0] = {pins_q, 5'h00} & impl_mask; // R01
            PDM_OFF_LAT: rd_word[7:0] = lat_q & impl_mask; // R10
            PDM_OFF_DIR: rd_word[7:0] = dir_q & impl_mask; // R10
            PDM_OFF_PORT_A_LATCH_AND_PULLUPS: rd_word[7:0] = port_a_latch_and_pullups_q;
            PDM_OFF_MODE: rd_word[4:0] = mode_q;
            default: rd_hit = 1'b0;
        endcase
    end

    // one read in flight; the next waits until the data is taken
    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= PDM_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? PDM_RESP_OKAY : PDM_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ==========================================================
    // pin multiplexer, priority: memory bus, host port, serial, port
    typedef enum {
        PDM_OWN_PORT,
        PDM_OWN_SPI_CLK,
        PDM_OWN_I2C,
        PDM_OWN_HOST,
        PDM_OWN_MEM
    } pdm_owner_e;

    pdm_owner_e owner [7:5];
    logic [7:5] drv_en;
    logic [7:5] drv_val;
    logic [7:5] impl_hi;
    logic [7:5] i2c_pull;
    logic [7:5] periph_ok;

    assign impl_hi = impl_mask[7:5];
    // open-drain i2c lines: a 0 from the module pulls the pad low
    assign i2c_pull = {1'b0, ~i2c_clock_out, ~i2c_data_out};
    // port and serial functions only live while the pins are ours
    assign periph_ok = {3{ext_bus_disable}} & impl_hi; // R10 R13

    // owner of each pin this cycle
    always_comb begin
        for (int i = 5; i <= 7; i++) begin
            owner[i] = PDM_OWN_PORT; // R01
            if (mem_owns) begin
                owner[i] = PDM_OWN_MEM; // R03 R13
            end else if (host_port_mode_bit) begin
                owner[i] = PDM_OWN_HOST; // R12
            end else if (i2c_mode && i != 7) begin
                owner[i] = PDM_OWN_I2C; // R08
            end else if (spi_mode && i == 6 && !dir_q[6]) begin
                owner[i] = PDM_OWN_SPI_CLK; // R07
            end
            // spi data in on pin 5 leaves the pin to its direction bit
        end
    end

    // drive enable and value of each pin from its owner
    always_comb begin
        drv_en = 3'b000;
        drv_val = 3'b000;
        for (int i = 5; i <= 7; i++) begin
            unique case (owner[i])
                PDM_OWN_MEM: begin
                    drv_en[i] = mem_bus_drive; // R04 R11
                    drv_val[i] = mem_bus_out[i]; // R04
                end
                PDM_OWN_HOST: begin
                    drv_en[i] = 1'b0; // R05 R11
                    drv_val[i] = lat_q[i]; // R05
                end
                PDM_OWN_I2C: begin
                    drv_en[i] = i2c_pull[i]; // R08
                    drv_val[i] = 1'b0; // R08
                end
                PDM_OWN_SPI_CLK: begin
                    drv_en[i] = 1'b1; // R07
                    drv_val[i] = spi_clock_out; // R07
                end
                PDM_OWN_PORT: begin
                    drv_en[i] = ~dir_q[i]; // R01
                    drv_val[i] = lat_q[i]; // R01
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_oe_n <= 3'b111; // R14
            pin_out <= 3'b000;
            pin_pullup <= 3'b000; // R14
            port_e_pullup_enable <= 1'b0; // R14
        end else begin
            pin_oe_n <= ~(drv_en & impl_hi); // R10
            pin_out <= drv_val;
            // pull-ups only on input pins that nothing drives
            pin_pullup <= {3{port_d_pullup_enable}} & periph_ok &
                          dir_q[7:5] & ~drv_en; // R02
            port_e_pullup_enable <= port_a_latch_and_pullups_q[PDM_BIT_PU_E]; // R02
        end
    end

    // ==========================================================
    // input sampling toward port and peripherals
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pins_q <= 3'b000;
            mem_bus_in <= 3'b000;
            host_wr_data <= 3'b000;
        end else begin
            pins_q <= pin_in & impl_hi; // R01
            mem_bus_in <= mem_owns ? pin_in : 3'b000; // R04
            if (host_port_mode_bit && ext_bus_disable && host_wr_strobe) begin
                host_wr_data <= pin_in; // R05
            end
        end
    end

    // serial module inputs, held idle while the memory bus owns the pins or the pin is absent
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            spi_data_in <= 1'b0;
            spi_clock_in <= 1'b0;
            spi_slave_select <= 1'b1;
            i2c_data_in <= 1'b1;
            i2c_clock_in <= 1'b1;
        end else begin
            spi_data_in <= periph_ok[5] & dir_q[5] & pin_in[5]; // R06 R13
            spi_clock_in <= periph_ok[6] & dir_q[6] & pin_in[6]; // R07
            spi_slave_select <= ~periph_ok[7] | pin_in[7]; // R09
            i2c_data_in <= ~periph_ok[5] | pin_in[5]; // R08
            i2c_clock_in <= ~periph_ok[6] | pin_in[6]; // R08
        end
    end
endmodule

// ===== verification/pdm_port_d_upper_sva.sv
// checker for the port d upper pin multiplexer top ports
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/100ps
module pdm_port_d_upper_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [7:5] pin_oe_n,
    input wire logic [7:5] pin_pullup
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ==========================================
    // pins
    a_reset_inputs: assert property (disable iff (1'b0)
        !aresetn |=> pin_oe_n == 3'h7 && pin_pullup == 3'h0)
        else $error("pins not inputs after reset");
    a_pullup_inputs: assert property (
        (pin_pullup & ~pin_oe_n) == 3'h0)
        else $error("pull-up on a driven pin");
    // ==========================================
    // register bus
    a_aw_blocked: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    a_b_release: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not released");
    a_r_follows: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_r_cause: assert property (
        $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
        else $error("read data without request");
    a_r_upper_zero: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_unmapped_err: assert property (s_axi_awvalid && s_axi_awready
        && !(s_axi_awaddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10})
        |-> ##[1:4] (s_axi_bvalid && s_axi_bresp == 2'h2))
        else $error("unmapped write not refused");
endmodule
bind pdm_port_d_upper pdm_port_d_upper_sva i_pdm_port_d_upper_sva (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata,
    .pin_oe_n, .pin_pullup);

// ===== verification/pdm_pin_model.sv
// pad model: device drive, outside driver, pull-up, else wander
// assumes pin enables are low while the device drives
`timescale 1ns/100ps
module pdm_pin_model (
    input wire logic aclk, // core clock
    input wire logic [7:5] pin_out, // device drive value
    input wire logic [7:5] pin_oe_n, // device enable, low drives
    input wire logic [7:5] pin_pullup, // weak pull-up on
    input wire logic [7:5] ext_val, // outside drive value
    input wire logic [7:5] ext_en, // outside party drives
    output logic [7:5] pin_in // resolved pad level
);
    logic [7:5] float_q = 3'h5;
    always_ff @(posedge aclk) begin
        float_q <= ~float_q;
    end
    always_comb begin
        for (int i = 5; i < 8; i++) begin
            pin_in[i] = !pin_oe_n[i] ? pin_out[i]
                : ext_en[i] ? ext_val[i]
                : pin_pullup[i] ? 1'b1 : float_q[i];
        end
    end
endmodule

// ===== verification/pdm_port_d_upper_tb.sv
// testbench for the port d upper pin multiplexer
// assumes the pin model and checker are compiled first
`timescale 1ns/100ps
module pdm_port_d_upper_tb;
    import pdm_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, q;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_bready, s_axi_rready, mem_bus_drive;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [7:5] pin_in, pin_out, pin_oe_n, pin_pullup, mem_bus_out;
    logic [7:5] mem_bus_in, host_wr_data, ext_val, ext_en;
    logic host_wr_strobe, spi_clock_out, i2c_data_out, i2c_clock_out;
    logic spi_data_in, spi_clock_in, spi_slave_select, i2c_data_in;
    logic i2c_clock_in, port_e_pullup_enable;
    int n_mismatch = 0;
    int checked = 0;
    pdm_port_d_upper i_pdm_port_d_upper (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in,
        .pin_out, .pin_oe_n, .pin_pullup, .mem_bus_out, .mem_bus_drive,
        .mem_bus_in, .host_wr_strobe, .host_wr_data, .spi_clock_out,
        .i2c_data_out, .i2c_clock_out, .spi_data_in, .spi_clock_in,
        .spi_slave_select, .i2c_data_in, .i2c_clock_in,
        .port_e_pullup_enable);
    pdm_pin_model i_pdm_pin_model (.aclk, .pin_out, .pin_oe_n,
        .pin_pullup, .ext_val, .ext_en, .pin_in);
    // ==========================================
    // tasks
    task automatic tally_and_finish;
        if (n_mismatch == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= wr;
        s_axi_wvalid <= wr;
        s_axi_arvalid <= !wr;
        do begin
            @(posedge aclk);
            n++;
            if (wr && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (wr && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (!wr && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(wr ? s_axi_bvalid : s_axi_rvalid) && n < 40);
        q = s_axi_rdata;
        r = wr ? s_axi_bresp : s_axi_rresp;
        if (n >= 40) begin
            n_mismatch++;
            tally_and_finish;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
        chk("bresp", r, PDM_RESP_OKAY);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk("rdata", q, e);
    endtask
    task automatic pause;
        repeat (3) @(posedge aclk);
    endtask
    // ==========================================
    // clock and sequence
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, aresetn} = '0;
        {mem_bus_drive, host_wr_strobe, spi_clock_out} = '0;
        {i2c_data_out, i2c_clock_out, s_axi_bready, s_axi_rready} = '1;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {mem_bus_out, ext_val, ext_en} = '0;
        s_axi_wstrb = 4'hF;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(PDM_OFF_DIR, 32'hFF);
        rd(PDM_OFF_PORT_A_LATCH_AND_PULLUPS, 32'h00);
        mem_bus_out <= 3'h5;
        mem_bus_drive <= 1'b1;
        pause;
        chk("mem_out", {pin_oe_n, pin_out}, 6'h05);
        mem_bus_drive <= 1'b0;
        ext_en <= 3'h7;
        ext_val <= 3'h6;
        pause;
        chk("mem_in", mem_bus_in, 3'h6);
        ext_en <= 3'h0;
        wr(PDM_OFF_MODE, 32'h01);
        wr(PDM_OFF_LAT, 32'hA0);
        wr(PDM_OFF_DIR, 32'h1F);
        pause;
        chk("port_out", {pin_oe_n, pin_out}, 6'h05);
        rd(PDM_OFF_PINS, 32'hA0);
        wr(PDM_OFF_DIR, 32'hFF);
        wr(PDM_OFF_PORT_A_LATCH_AND_PULLUPS, 32'h80);
        pause;
        chk("pullup_d", {port_e_pullup_enable, pin_pullup}, 4'h7);
        ext_en <= 3'h7;
        ext_val <= 3'h2;
        wr(PDM_OFF_PORT_A_LATCH_AND_PULLUPS, 32'h40);
        pause;
        chk("pullup_e", {port_e_pullup_enable, pin_pullup}, 4'h8);
        rd(PDM_OFF_PINS, 32'h40);
        ext_val <= 3'h1;
        spi_clock_out <= 1'b1;
        wr(PDM_OFF_MODE, 32'h09);
        wr(PDM_OFF_DIR, 32'hBF);
        pause;
        chk("spi_mst", {spi_slave_select, spi_data_in, pin_oe_n[6],
            pin_out[6]}, 4'h5);
        ext_val <= 3'h6;
        wr(PDM_OFF_DIR, 32'hFF);
        pause;
        chk("spi_slv", {spi_slave_select, spi_clock_in, pin_oe_n[6]},
            3'h7);
        i2c_data_out <= 1'b0;
        ext_en <= 3'h2;
        ext_val <= 3'h0;
        wr(PDM_OFF_MODE, 32'h05);
        pause;
        chk("i2c", {pin_oe_n[5], pin_out[5], i2c_data_in, i2c_clock_in},
            4'h0);
        i2c_data_out <= 1'b1;
        host_wr_strobe <= 1'b1;
        ext_en <= 3'h7;
        ext_val <= 3'h3;
        wr(PDM_OFF_MODE, 32'h03);
        pause;
        chk("host", {pin_out, host_wr_data}, 6'h2B);
        host_wr_strobe <= 1'b0;
        wr(PDM_OFF_MODE, 32'h11);
        wr(PDM_OFF_LAT, 32'hFF);
        rd(PDM_OFF_LAT, 32'h07);
        rd(PDM_OFF_DIR, 32'h07);
        s_axi_wstrb <= 4'hE;
        wr(PDM_OFF_LAT, 32'h00);
        rd(PDM_OFF_LAT, 32'h07);
        s_axi_wstrb <= 4'hF;
        bus(1'b1, 8'h20, 32'h0);
        chk("wr_unmapped", r, PDM_RESP_SLVERR);
        bus(1'b0, 8'h20, 32'h0);
        chk("rd_unmapped", r, PDM_RESP_SLVERR);
        tally_and_finish;
    end
endmodule
